// *** rtl/clu_pkg.sv ***
// Constants, register map and encodings of the custom logic unit
package clu_pkg;

  localparam int unsigned ADDR_W    = 6;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned SEL_W     = 4;
  localparam int unsigned FILT_W    = 2;
  localparam int unsigned TRUTH_W   = 8;

  // Byte addresses of the registers
  localparam logic [5:0] OFF_GLOBAL_CONTROL = 6'h00;
  localparam logic [5:0] OFF_SEQ_CONTROL_0  = 6'h04;
  localparam logic [5:0] OFF_T0_CONTROL_A   = 6'h08;
  localparam logic [5:0] OFF_T0_CONTROL_B   = 6'h0C;
  localparam logic [5:0] OFF_T0_CONTROL_C   = 6'h10;
  localparam logic [5:0] OFF_T0_FUNCTION    = 6'h14;
  localparam logic [5:0] OFF_T1_CONTROL_A   = 6'h18;
  localparam logic [5:0] OFF_T1_CONTROL_B   = 6'h1C;
  localparam logic [5:0] OFF_T1_CONTROL_C   = 6'h20;
  localparam logic [5:0] OFF_T1_FUNCTION    = 6'h24;
  localparam logic [5:0] OFF_STATUS         = 6'h28;

  // Field positions
  localparam int unsigned GC_ENABLE_BIT   = 0;
  localparam int unsigned GC_RUNSTBY_BIT  = 6;
  localparam int unsigned CA_ENABLE_BIT   = 0;
  localparam int unsigned CA_FILT_LSB     = 4;
  localparam int unsigned CA_TABLE_CLOCK_SOURCE_SELECT_BIT   = 6;
  localparam int unsigned CB_SEL0_LSB     = 0;
  localparam int unsigned CB_SEL1_LSB     = 4;
  localparam int unsigned CC_SEL2_LSB     = 0;
  localparam int unsigned SEQ_SEL_LSB     = 0;

  // Values after reset
  localparam logic [7:0] RST_TRUTH  = 8'h00;
  localparam logic [3:0] RST_SEL    = 4'h0;
  localparam logic [1:0] RST_FILT   = 2'h0;

  // Input source selections
  localparam logic [3:0] SRC_MASK     = 4'h0;
  localparam logic [3:0] SRC_FEEDBACK = 4'h1;
  localparam logic [3:0] SRC_LINK     = 4'h2;
  localparam logic [3:0] SRC_EVENT0   = 4'h3;
  localparam logic [3:0] SRC_EVENT1   = 4'h4;
  localparam logic [3:0] SRC_PIN      = 4'h5;
  localparam logic [3:0] SRC_COMPARE  = 4'h6;
  localparam logic [3:0] SRC_WAVE     = 4'h7;

  // Output filter selections
  localparam logic [1:0] FILT_OFF     = 2'h0;
  localparam logic [1:0] FILT_SYNC    = 2'h1;
  localparam logic [1:0] FILT_FILTER  = 2'h2;

  // Sequencer functions
  localparam logic [3:0] SEQ_DISABLE  = 4'h0;
  localparam logic [3:0] SEQ_DFF      = 4'h1;
  localparam logic [3:0] SEQ_JK       = 4'h2;
  localparam logic [3:0] SEQ_DLATCH   = 4'h3;
  localparam logic [3:0] SEQ_RS       = 4'h4;

endpackage

// *** rtl/clu_table.sv ***
// One three-input lookup table with source selection and output filter
`timescale 1ns/1ps
module clu_table (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic [7:0] truth,
  input  wire logic [3:0] sel0,
  input  wire logic [3:0] sel1,
  input  wire logic [3:0] sel2,
  input  wire logic       table_clock_source_select,
  input  wire logic [1:0] filtsel,
  input  wire logic [2:0] pin_in,
  input  wire logic [1:0] event_in,
  input  wire logic       compare_in,
  input  wire logic [2:0] wave_in,
  input  wire logic       feedback_in,
  input  wire logic       link_in,
  output logic            lut_out,
  output logic            filt_out,
  output logic            tick
);

  logic [3:0] sel [3];
  logic [2:0] raw;
  logic [2:0] idx;
  logic       in2_prev_reg;
  logic       in2_prev_next;
  logic [2:0] shift_reg;
  logic [2:0] shift_next;
  logic       hold_reg;
  logic       hold_next;

  assign sel[0] = sel0;
  assign sel[1] = sel1;
  assign sel[2] = sel2;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      case (sel[i])
        clu_pkg::SRC_MASK:     raw[i] = 1'b0;
        clu_pkg::SRC_FEEDBACK: raw[i] = feedback_in;
        clu_pkg::SRC_LINK:     raw[i] = link_in;
        clu_pkg::SRC_EVENT0:   raw[i] = event_in[0];
        clu_pkg::SRC_EVENT1:   raw[i] = event_in[1];
        clu_pkg::SRC_PIN:      raw[i] = pin_in[i];
        clu_pkg::SRC_COMPARE:  raw[i] = compare_in;
        clu_pkg::SRC_WAVE:     raw[i] = wave_in[i];
        default:               raw[i] = 1'b0;
      endcase
    end
    // Input 2 used as clock never reaches the function bits
    idx     = {raw[2] & ~table_clock_source_select, raw[1], raw[0]};
    lut_out = truth[idx];
    // Rising edge of input 2 stands in for its clock
    tick    = table_clock_source_select ? (raw[2] & ~in2_prev_reg) : 1'b1;
  end

  always_comb begin
    in2_prev_next = raw[2];
    shift_next    = shift_reg;
    hold_next     = hold_reg;
    if (!enable) begin
      shift_next = 3'h0;
      hold_next  = 1'b0;
    end else if (tick) begin
      shift_next = {shift_reg[1:0], lut_out};
      if (&shift_reg || ~|shift_reg) begin
        hold_next = shift_reg[2];
      end
    end
    case (filtsel)
      clu_pkg::FILT_SYNC:   filt_out = shift_reg[1];
      clu_pkg::FILT_FILTER: filt_out = hold_reg;
      default:              filt_out = lut_out;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      in2_prev_reg <= 1'b0;
      shift_reg    <= 3'h0;
      hold_reg     <= 1'b0;
    end else begin
      in2_prev_reg <= in2_prev_next;
      shift_reg    <= shift_next;
      hold_reg     <= hold_next;
    end
  end

  AST_MASK_ALL: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (sel0 == clu_pkg::SRC_MASK && sel1 == clu_pkg::SRC_MASK &&
     sel2 == clu_pkg::SRC_MASK) |-> lut_out == truth[0])
    else $error("masked inputs did not select bit 0");

  AST_TABLE_CLOCK_SOURCE_SELECT_MASK: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (table_clock_source_select && sel0 == clu_pkg::SRC_MASK && sel1 == clu_pkg::SRC_MASK)
    |-> lut_out == truth[0])
    else $error("input 2 not masked while used as clock");

  AST_SYNC_DELAY: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (enable && !table_clock_source_select && filtsel == clu_pkg::FILT_SYNC)[*3]
    |-> filt_out == $past(lut_out, 2))
    else $error("synchroniser delay is not two cycles");

endmodule // clu_table

// *** rtl/clu_top.sv ***
// Custom logic unit: two lookup tables, sequencer and register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module clu_top #(
  parameter int unsigned TABLES = 2
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [2:0]  table_input_pins_0,
  input  wire logic [2:0]  table_input_pins_1,
  input  wire logic [1:0]  event_in,
  input  wire logic [1:0]  compare_in,
  input  wire logic [2:0]  wave_in,
  output logic [1:0]       table_output_pin,
  output logic [1:0]       table_output_event
);

  logic        wait_reg;
  logic        wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] rd_mux;
  logic        wr_take;
  logic [7:0]  wbyte;

  logic        glob_en_reg;
  logic        glob_en_next;
  logic        runstby_reg;
  logic        runstby_next;
  logic [3:0]  sequencer_function_select_reg;
  logic [3:0]  sequencer_function_select_next;
  logic [1:0]  tab_en_reg;
  logic [1:0]  tab_en_next;
  logic [1:0]  table_clock_source_select_reg;
  logic [1:0]  table_clock_source_select_next;
  logic [1:0]  filt_reg   [2];
  logic [1:0]  filt_next  [2];
  logic [3:0]  sel0_reg   [2];
  logic [3:0]  sel0_next  [2];
  logic [3:0]  sel1_reg   [2];
  logic [3:0]  sel1_next  [2];
  logic [3:0]  sel2_reg   [2];
  logic [3:0]  sel2_next  [2];
  logic [7:0]  truth_reg  [2];
  logic [7:0]  truth_next [2];

  logic        seq_reg;
  logic        seq_next;
  logic [1:0]  pin_reg;
  logic [1:0]  pin_next;
  logic [1:0]  lut_out;
  logic [1:0]  filt_out;
  logic [1:0]  tick;
  logic [1:0]  run;
  logic [1:0]  value;
  logic [5:0]  offs_a [2];
  logic [5:0]  offs_b [2];
  logic [5:0]  offs_c [2];
  logic [5:0]  offs_f [2];

  assign offs_a = '{clu_pkg::OFF_T0_CONTROL_A, clu_pkg::OFF_T1_CONTROL_A};
  assign offs_b = '{clu_pkg::OFF_T0_CONTROL_B, clu_pkg::OFF_T1_CONTROL_B};
  assign offs_c = '{clu_pkg::OFF_T0_CONTROL_C, clu_pkg::OFF_T1_CONTROL_C};
  assign offs_f = '{clu_pkg::OFF_T0_FUNCTION, clu_pkg::OFF_T1_FUNCTION};

  // One wait cycle per access; the write lands on the acknowledging edge
  always_comb begin
    wait_next = ~((avs_read | avs_write) & wait_reg);
    wr_take   = avs_write & ~wait_reg & avs_byteenable[0];
    wbyte     = avs_writedata[7:0];
    rd_mux    = 32'h0000_0000;
    case (avs_address)
      clu_pkg::OFF_GLOBAL_CONTROL: begin
        rd_mux[clu_pkg::GC_ENABLE_BIT]  = glob_en_reg;
        rd_mux[clu_pkg::GC_RUNSTBY_BIT] = runstby_reg;
      end
      clu_pkg::OFF_SEQ_CONTROL_0: rd_mux[3:0] = sequencer_function_select_reg;
      clu_pkg::OFF_STATUS:        rd_mux[2:0] = {seq_reg, pin_reg};
      default: begin
        for (int t = 0; t < 2; t++) begin
          if (avs_address == offs_a[t]) begin
            rd_mux[clu_pkg::CA_ENABLE_BIT] = tab_en_reg[t];
            rd_mux[clu_pkg::CA_TABLE_CLOCK_SOURCE_SELECT_BIT] = table_clock_source_select_reg[t];
            rd_mux[clu_pkg::CA_FILT_LSB +: 2] = filt_reg[t];
          end
          if (avs_address == offs_b[t]) begin
            rd_mux[7:0] = {sel1_reg[t], sel0_reg[t]};
          end
          if (avs_address == offs_c[t]) begin
            rd_mux[3:0] = sel2_reg[t];
          end
          if (avs_address == offs_f[t]) begin
            rd_mux[7:0] = truth_reg[t];
          end
        end
      end
    endcase
    rdata_next = (avs_read & wait_reg) ? rd_mux : rdata_reg;
  end

  // Register writes
  always_comb begin
    glob_en_next = glob_en_reg;
    runstby_next = runstby_reg;
    sequencer_function_select_next  = sequencer_function_select_reg;
    tab_en_next  = tab_en_reg;
    table_clock_source_select_next  = table_clock_source_select_reg;
    filt_next    = filt_reg;
    sel0_next    = sel0_reg;
    sel1_next    = sel1_reg;
    sel2_next    = sel2_reg;
    truth_next   = truth_reg;
    if (wr_take) begin
      if (avs_address == clu_pkg::OFF_GLOBAL_CONTROL) begin
        glob_en_next = wbyte[clu_pkg::GC_ENABLE_BIT];
        runstby_next = wbyte[clu_pkg::GC_RUNSTBY_BIT];
      end
      if (avs_address == clu_pkg::OFF_SEQ_CONTROL_0 && !tab_en_reg[0]) begin
        sequencer_function_select_next = wbyte[clu_pkg::SEQ_SEL_LSB +: 4];
      end
      for (int t = 0; t < 2; t++) begin
        if (avs_address == offs_a[t]) begin
          tab_en_next[t] = wbyte[clu_pkg::CA_ENABLE_BIT];
          // Fields load only while the table was off, so the enabling
          // write carries them and a disabling write does not
          if (!tab_en_reg[t]) begin
            table_clock_source_select_next[t] = wbyte[clu_pkg::CA_TABLE_CLOCK_SOURCE_SELECT_BIT];
            filt_next[t]   = wbyte[clu_pkg::CA_FILT_LSB +: 2];
          end
        end
        if (avs_address == offs_b[t] && !tab_en_reg[t]) begin
          sel0_next[t] = wbyte[clu_pkg::CB_SEL0_LSB +: 4];
          sel1_next[t] = wbyte[clu_pkg::CB_SEL1_LSB +: 4];
        end
        if (avs_address == offs_c[t] && !tab_en_reg[t]) begin
          sel2_next[t] = wbyte[clu_pkg::CC_SEL2_LSB +: 4];
        end
        if (avs_address == offs_f[t]) begin
          truth_next[t] = wbyte;
        end
      end
    end
  end

  assign run = {2{glob_en_reg}} & tab_en_reg;

  // Table 1 has no higher neighbour, so its link reads low
  clu_table u_table0 (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .enable      (run[0]),
    .truth       (truth_reg[0]),
    .sel0        (sel0_reg[0]),
    .sel1        (sel1_reg[0]),
    .sel2        (sel2_reg[0]),
    .table_clock_source_select      (table_clock_source_select_reg[0]),
    .filtsel     (filt_reg[0]),
    .pin_in      (table_input_pins_0),
    .event_in    (event_in),
    .compare_in  (compare_in[0]),
    .wave_in     (wave_in),
    .feedback_in (seq_reg),
    .link_in     (lut_out[1]),
    .lut_out     (lut_out[0]),
    .filt_out    (filt_out[0]),
    .tick        (tick[0])
  );

  clu_table u_table1 (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .enable      (run[1]),
    .truth       (truth_reg[1]),
    .sel0        (sel0_reg[1]),
    .sel1        (sel1_reg[1]),
    .sel2        (sel2_reg[1]),
    .table_clock_source_select      (table_clock_source_select_reg[1]),
    .filtsel     (filt_reg[1]),
    .pin_in      (table_input_pins_1),
    .event_in    (event_in),
    .compare_in  (compare_in[1]),
    .wave_in     (wave_in),
    .feedback_in (seq_reg),
    .link_in     (1'b0),
    .lut_out     (lut_out[1]),
    .filt_out    (filt_out[1]),
    .tick        (tick[1])
  );

  // Sequencer: latches act every cycle, flip-flops on the even tick only
  always_comb begin
    seq_next = seq_reg;
    if (!run[0]) begin
      seq_next = 1'b0;
    end else begin
      case (sequencer_function_select_reg)
        clu_pkg::SEQ_DFF: begin
          if (tick[0] && filt_out[1]) seq_next = filt_out[0];
        end
        clu_pkg::SEQ_JK: begin
          if (tick[0]) begin
            case ({filt_out[0], filt_out[1]})
              2'b01:   seq_next = 1'b0;
              2'b10:   seq_next = 1'b1;
              2'b11:   seq_next = ~seq_reg;
              default: seq_next = seq_reg;
            endcase
          end
        end
        clu_pkg::SEQ_DLATCH: begin
          if (filt_out[1]) seq_next = filt_out[0];
        end
        clu_pkg::SEQ_RS: begin
          // Both set and reset high is forbidden; state is held
          if (filt_out[0] && !filt_out[1]) seq_next = 1'b1;
          if (!filt_out[0] && filt_out[1]) seq_next = 1'b0;
        end
        default: seq_next = 1'b0;
      endcase
    end
  end

  // Nothing here looks at the processor, so a debug halt changes nothing
  always_comb begin
    value[0] = (sequencer_function_select_reg == clu_pkg::SEQ_DISABLE) ? filt_out[0] : seq_reg;
    value[1] = filt_out[1];
    pin_next = run & value;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wait_reg    <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
      glob_en_reg <= 1'b0;
      runstby_reg <= 1'b0;
      sequencer_function_select_reg  <= clu_pkg::SEQ_DISABLE;
      tab_en_reg  <= 2'h0;
      table_clock_source_select_reg  <= 2'h0;
      seq_reg     <= 1'b0;
      pin_reg     <= 2'h0;
      for (int t = 0; t < 2; t++) begin
        filt_reg[t]  <= clu_pkg::RST_FILT;
        sel0_reg[t]  <= clu_pkg::RST_SEL;
        sel1_reg[t]  <= clu_pkg::RST_SEL;
        sel2_reg[t]  <= clu_pkg::RST_SEL;
        truth_reg[t] <= clu_pkg::RST_TRUTH;
      end
    end else begin
      wait_reg    <= wait_next;
      rdata_reg   <= rdata_next;
      glob_en_reg <= glob_en_next;
      runstby_reg <= runstby_next;
      sequencer_function_select_reg  <= sequencer_function_select_next;
      tab_en_reg  <= tab_en_next;
      table_clock_source_select_reg  <= table_clock_source_select_next;
      seq_reg     <= seq_next;
      pin_reg     <= pin_next;
      filt_reg    <= filt_next;
      sel0_reg    <= sel0_next;
      sel1_reg    <= sel1_next;
      sel2_reg    <= sel2_next;
      truth_reg   <= truth_next;
    end
  end

  assign avs_waitrequest    = wait_reg;
  assign avs_readdata       = rdata_reg;
  assign table_output_pin   = pin_reg;
  assign table_output_event = pin_reg;

  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_write_b0_locked;
    wr_take && avs_address == clu_pkg::OFF_T0_CONTROL_B && tab_en_reg[0];
  endsequence
  sequence s_enable_t0;
    wr_take && avs_address == clu_pkg::OFF_T0_CONTROL_A && !tab_en_reg[0]
      && avs_writedata[clu_pkg::CA_ENABLE_BIT];
  endsequence

  AST_WAIT_ONE: assert property (
    (avs_read || avs_write) && wait_reg |=> !wait_reg ##1 wait_reg)
    else $error("access not acknowledged after one wait cycle");
  AST_GLOBAL_OFF: assert property (
    !glob_en_reg |=> table_output_pin == 2'h0)
    else $error("output active while unit disabled");
  AST_TABLE_OFF: assert property (
    !tab_en_reg[1] |=> !table_output_pin[1])
    else $error("table 1 output active while disabled");
  AST_SEQUENCER_FUNCTION_SELECT_LOCK: assert property (
    wr_take && avs_address == clu_pkg::OFF_SEQ_CONTROL_0 && tab_en_reg[0]
    |=> $stable(sequencer_function_select_reg))
    else $error("sequencer select changed while even table on");
  AST_CTRL_LOCK: assert property (
    s_write_b0_locked |=> $stable(sel0_reg[0]) && $stable(sel1_reg[0]))
    else $error("locked input select changed");
  AST_ENABLE_LOADS: assert property (
    s_enable_t0 |=> tab_en_reg[0] &&
      table_clock_source_select_reg[0] == $past(avs_writedata[clu_pkg::CA_TABLE_CLOCK_SOURCE_SELECT_BIT]))
    else $error("enabling write did not load clock source");
  AST_SEQ_CLEAR: assert property (
    !run[0] |=> !seq_reg && !table_output_pin[0])
    else $error("sequencer not cleared with even table off");
  AST_PIN_EVENT: assert property (
    table_output_pin == table_output_event)
    else $error("pin and event outputs differ");

endmodule // clu_top

// *** tb/clu_far_model.sv ***
// Far-side model: pins, event channels, comparators and timer waveforms
`timescale 1ns/1ps
module clu_far_model (
  input  wire logic       core_clk,
  input  wire logic [2:0] scene,
  output logic      [2:0] pins_0,
  output logic      [2:0] pins_1,
  output logic      [1:0] events,
  output logic      [1:0] compares,
  output logic      [2:0] waves
);
  // Sources move only at clock edges, like synchronous peripherals
  always_ff @(posedge core_clk) begin
    pins_0   <= scene;
    pins_1   <= scene;
    events   <= ~scene[1:0];
    compares <= scene[2:1];
    waves    <= ~scene;
  end
endmodule // clu_far_model

// *** tb/tb_top.sv ***
// Register-level testbench of the custom logic unit
`timescale 1ns/1ps
module tb_top;
  logic        core_clk;
  logic        rst_n;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  scene;
  logic [2:0]  pins_0;
  logic [2:0]  pins_1;
  logic [1:0]  events;
  logic [1:0]  compares;
  logic [2:0]  waves;
  logic [1:0]  out_pin;
  logic [1:0]  out_evt;
  logic [31:0] rd;
  int          fail_count;
  int          samples_checked;

  clu_top dut (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .table_input_pins_0(pins_0), .table_input_pins_1(pins_1),
    .event_in(events), .compare_in(compares), .wave_in(waves),
    .table_output_pin(out_pin), .table_output_event(out_evt)
  );

  clu_far_model far (
    .core_clk(core_clk), .scene(scene), .pins_0(pins_0),
    .pins_1(pins_1), .events(events), .compares(compares), .waves(waves)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Request holds until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("readback", rd, {24'h000000, e});
  endtask

  // Three edges: one through the far model, one through the output register, one spare
  task automatic apply(input logic [2:0] s);
    @(posedge core_clk);
    scene <= s;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    results();
  end

  initial begin
    rst_n = 1'b0; avs_address = 6'h00; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h00000000; avs_byteenable = 4'h1; scene = 3'h0;
    fail_count = 0; samples_checked = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 8'h2C; a += 4) rdchk(a[5:0], 8'h00);
    wr(clu_pkg::OFF_T0_CONTROL_B, 8'h55);
    wr(clu_pkg::OFF_T0_CONTROL_C, 8'h05);
    wr(clu_pkg::OFF_T0_FUNCTION, 8'hB4);
    wr(clu_pkg::OFF_T1_CONTROL_B, 8'h55);
    wr(clu_pkg::OFF_T1_CONTROL_C, 8'h05);
    wr(clu_pkg::OFF_T1_FUNCTION, 8'h96);
    wr(clu_pkg::OFF_T0_CONTROL_A, 8'h31);
    wr(clu_pkg::OFF_T1_CONTROL_A, 8'h01);
    wr(clu_pkg::OFF_GLOBAL_CONTROL, 8'h01);
    rdchk(clu_pkg::OFF_T0_CONTROL_A, 8'h31);
    for (int v = 0; v < 8; v++) begin
      apply(v[2:0]);
      chk("out0", out_pin[0], (8'hB4 >> v) & 1);
      chk("out1", out_pin[1], (8'h96 >> v) & 1);
      chk("evt", out_evt, out_pin);
    end
    wr(clu_pkg::OFF_T0_CONTROL_B, 8'h00);
    rdchk(clu_pkg::OFF_T0_CONTROL_B, 8'h55);
    wr(clu_pkg::OFF_SEQ_CONTROL_0, 8'h01);
    rdchk(clu_pkg::OFF_SEQ_CONTROL_0, 8'h00);
    wr(clu_pkg::OFF_GLOBAL_CONTROL, 8'h00);
    apply(3'h7);
    chk("global off", out_pin, 32'h0);
    wr(clu_pkg::OFF_T0_CONTROL_A, 8'h10);
    rdchk(clu_pkg::OFF_T0_CONTROL_A, 8'h30);
    wr(clu_pkg::OFF_SEQ_CONTROL_0, 8'h01);
    rdchk(clu_pkg::OFF_SEQ_CONTROL_0, 8'h01);
    wr(clu_pkg::OFF_SEQ_CONTROL_0, 8'h00);
    wr(clu_pkg::OFF_T0_CONTROL_C, 8'h00);
    wr(clu_pkg::OFF_T0_CONTROL_A, 8'h01);
    wr(clu_pkg::OFF_GLOBAL_CONTROL, 8'h01);
    apply(3'h7);
    chk("masked", out_pin, 32'h2);
    wr(clu_pkg::OFF_T1_CONTROL_A, 8'h00);
    apply(3'h7);
    chk("table off", out_pin, 32'h0);
    wr(clu_pkg::OFF_T0_CONTROL_A, 8'h00);
    wr(clu_pkg::OFF_T0_CONTROL_B, 8'h02);
    wr(clu_pkg::OFF_T0_FUNCTION, 8'h02);
    wr(clu_pkg::OFF_T1_CONTROL_B, 8'h02);
    wr(clu_pkg::OFF_T1_CONTROL_C, 8'h00);
    wr(clu_pkg::OFF_T1_FUNCTION, 8'h01);
    wr(clu_pkg::OFF_T0_CONTROL_A, 8'h01);
    wr(clu_pkg::OFF_T1_CONTROL_A, 8'h01);
    apply(3'h5);
    chk("link high", out_pin, 32'h3);
    rdchk(clu_pkg::OFF_STATUS, 8'h03);
    wr(clu_pkg::OFF_T1_FUNCTION, 8'h00);
    apply(3'h5);
    chk("link low", out_pin, 32'h0);
    wr(clu_pkg::OFF_GLOBAL_CONTROL, 8'h00);
    wr(clu_pkg::OFF_T1_CONTROL_A, 8'h00);
    wr(clu_pkg::OFF_T1_CONTROL_B, 8'h00);
    wr(clu_pkg::OFF_T1_CONTROL_C, 8'h05);
    wr(clu_pkg::OFF_T1_FUNCTION, 8'h10);
    wr(clu_pkg::OFF_T1_CONTROL_A, 8'h41);
    wr(clu_pkg::OFF_GLOBAL_CONTROL, 8'h01);
    apply(3'h4);
    chk("clock input masked", out_pin, 32'h0);
    wr(clu_pkg::OFF_GLOBAL_CONTROL, 8'h00);
    wr(clu_pkg::OFF_T1_CONTROL_A, 8'h00);
    wr(clu_pkg::OFF_T1_CONTROL_A, 8'h11);
    wr(clu_pkg::OFF_GLOBAL_CONTROL, 8'h01);
    apply(3'h0);
    apply(3'h4);
    chk("sync early", out_pin[1], 32'h0);
    @(posedge core_clk);
    #1;
    chk("sync late", out_pin[1], 32'h1);
    wr(clu_pkg::OFF_T0_CONTROL_A, 8'h00);
    wr(clu_pkg::OFF_SEQ_CONTROL_0, 8'h01);
    wr(clu_pkg::OFF_T0_CONTROL_A, 8'h01);
    apply(3'h0);
    apply(3'h4);
    chk("dff hold", out_pin[0], 32'h0);
    repeat (2) @(posedge core_clk);
    #1;
    chk("dff load", out_pin[0], 32'h1);
    results();
  end
endmodule // tb_top
